// ===== rtl/rtc_pkg.sv
package rtc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFFSET  = 12'h000;
	localparam logic [11:0] ALARM_OFFSET = 12'h004;
	localparam logic [11:0] TIME_OFFSET  = 12'h008;
	localparam logic [11:0] ALTIM_OFFSET = 12'h00C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ON_BIT     = 15;
	localparam int CTRL_WREN_BIT   = 3;
	localparam int ALARM_EN_BIT    = 15;
	localparam int ALARM_ENDLESS_REPEAT_BIT = 14;
	localparam int ALARM_SYNC_BIT  = 12;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  RPT_RESET   = 8'h00;
	localparam logic [7:0]  RPT_MAX     = 8'hFF;
	localparam logic [23:0] TIME_RESET  = 24'h00_0000;
	localparam int          CLK_HZ      = 20_000_000;
	localparam int          TICK_CYCLES = CLK_HZ;
	localparam logic [3:0]  BCD_NINE    = 4'h9;
	localparam logic [3:0]  BCD_FIVE    = 4'h5;
	localparam logic [3:0]  BCD_TWO     = 4'h2;
	localparam logic [3:0]  BCD_THREE   = 4'h3;

	typedef struct packed {
		logic [3:0] hours_tens;
		logic [3:0] hours_units;
		logic [3:0] minutes_tens;
		logic [3:0] minutes_units;
		logic [3:0] seconds_tens;
		logic [3:0] seconds_units;
	} bcd_time_s;

endpackage : rtc_pkg

// ===== rtl/rtc_tick_gen.sv
`timescale 1ns/1ps
module rtc_tick_gen #(
	parameter int TICK_CYCLES = rtc_pkg::TICK_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	output logic      tick
);
	logic [31:0] cnt_q;

	// restarting on stop keeps the first second full length after switch-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_q <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
			cnt_q <= 32'h0000_0000;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
			tick  <= 1'b0;
		end
	end
endmodule : rtc_tick_gen

// ===== rtl/rtc_bcd_counter.sv
`timescale 1ns/1ps
module rtc_bcd_counter (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               tick,
	input  wire logic               load,
	input  wire rtc_pkg::bcd_time_s load_val,
	output rtc_pkg::bcd_time_s      time_q
);
	rtc_pkg::bcd_time_s time_d;

	always_comb begin
		time_d = time_q;
		if (time_q.seconds_units != rtc_pkg::BCD_NINE) begin
			time_d.seconds_units = time_q.seconds_units + 4'h1;
		end else begin
			time_d.seconds_units = 4'h0;
			if (time_q.seconds_tens != rtc_pkg::BCD_FIVE) begin
				time_d.seconds_tens = time_q.seconds_tens + 4'h1;
			end else begin
				time_d.seconds_tens = 4'h0;
				if (time_q.minutes_units != rtc_pkg::BCD_NINE) begin
					time_d.minutes_units = time_q.minutes_units + 4'h1;
				end else begin
					time_d.minutes_units = 4'h0;
					if (time_q.minutes_tens != rtc_pkg::BCD_FIVE) begin
						time_d.minutes_tens = time_q.minutes_tens + 4'h1;
					end else begin
						time_d.minutes_tens = 4'h0;
						// 23 -> 00 before the plain units carry
						if (time_q.hours_tens == rtc_pkg::BCD_TWO &&
						    time_q.hours_units == rtc_pkg::BCD_THREE) begin
							time_d.hours_tens  = 4'h0;
							time_d.hours_units = 4'h0;
						end else if (time_q.hours_units != rtc_pkg::BCD_NINE) begin
							time_d.hours_units = time_q.hours_units + 4'h1;
						end else begin
							time_d.hours_units = 4'h0;
							time_d.hours_tens  = time_q.hours_tens + 4'h1;
						end
					end
				end
			end
		end
	end

	// a software load wins over a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_q <= rtc_pkg::TIME_RESET;
		end else if (load) begin
			time_q <= load_val;
		end else if (tick) begin
			time_q <= time_d; // R12
		end
	end
endmodule : rtc_bcd_counter

// ===== rtl/rtc_alarm_time.sv
`timescale 1ns/1ps
// How it works
// R1: 8-bit repeat count; 0xFF gives 256 alarms, 0x00 gives one.
// R2: each alarm event lowers the repeat count by one.
// R3: count wraps 0x00 to 0xFF only with endless repeat set.
// R4: event at count zero without endless repeat clears alarm enable.
// R5: software avoids writing repeat count while on and sync flag set.
// R6: alarm control is cleared only by power-on reset.
// R7: hours in BCD, tens 0..2 in bits 31:28, units in 27:24.
// R8: minutes in BCD, tens 0..5 in 23:20, units in 19:16.
// R9: seconds in BCD, tens 0..5 in 15:12, units in 11:8.
// R10: lowest byte of the time register reads zero.
// R11: time writes are taken only while clock write enable is one.
// R12: time advances once per second with decimal carries, 23:59:59 to 00:00:00.
// R13: alarm event fires when enabled and running time matches alarm time.
module rtc_alarm_time #(
	parameter int TICK_CYCLES = rtc_pkg::TICK_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             alarm_event
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic               module_on_q;
	logic               clock_write_enable_q;
	logic               alarm_enable_q;
	logic               endless_repeat_q;
	logic               alarm_sync_flag_q;
	logic [7:0]         alarm_repeat_count_q;
	logic [23:0]        alarm_time_q;
	rtc_pkg::bcd_time_s time_q;
	logic               tick;
	logic               match_seen_q;
	logic               wr_en;
	logic               rd_en;
	logic               fire;
	logic               time_load;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic mapped(input logic [11:0] a);
		mapped = hit(a, rtc_pkg::CTRL_OFFSET) || hit(a, rtc_pkg::ALARM_OFFSET) ||
		         hit(a, rtc_pkg::TIME_OFFSET) || hit(a, rtc_pkg::ALTIM_OFFSET);
	endfunction : mapped

	// ----------------------------------------------------------------
	// bus
	// ----------------------------------------------------------------
	// the slave answers in the first access cycle, so no wait states
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !mapped(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= 32'h0000_0000;
			if (hit(paddr, rtc_pkg::CTRL_OFFSET)) begin
				prdata[rtc_pkg::CTRL_ON_BIT]   <= module_on_q;
				prdata[rtc_pkg::CTRL_WREN_BIT] <= clock_write_enable_q;
			end else if (hit(paddr, rtc_pkg::ALARM_OFFSET)) begin
				prdata[rtc_pkg::ALARM_EN_BIT]    <= alarm_enable_q;
				prdata[rtc_pkg::ALARM_ENDLESS_REPEAT_BIT] <= endless_repeat_q;
				prdata[rtc_pkg::ALARM_SYNC_BIT]  <= alarm_sync_flag_q;
				prdata[7:0]                      <= alarm_repeat_count_q;
			end else if (hit(paddr, rtc_pkg::TIME_OFFSET)) begin
				prdata[31:8] <= time_q; // R7 R8 R9
				prdata[7:0]  <= 8'h00; // R10
			end else if (hit(paddr, rtc_pkg::ALTIM_OFFSET)) begin
				prdata[31:8] <= alarm_time_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// clock control
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_on_q          <= 1'b0;
			clock_write_enable_q <= 1'b0;
		end else if (wr_en && hit(paddr, rtc_pkg::CTRL_OFFSET)) begin
			module_on_q          <= pwdata[rtc_pkg::CTRL_ON_BIT];
			clock_write_enable_q <= pwdata[rtc_pkg::CTRL_WREN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// time of day
	// ----------------------------------------------------------------
	assign time_load = wr_en && hit(paddr, rtc_pkg::TIME_OFFSET) &&
	                   clock_write_enable_q; // R11

	rtc_tick_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (module_on_q),
		.tick    (tick)
	);

	rtc_bcd_counter u_count (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (tick),
		.load     (time_load),
		.load_val (rtc_pkg::bcd_time_s'(pwdata[31:8])),
		.time_q   (time_q)
	);

	// ----------------------------------------------------------------
	// alarm match
	// ----------------------------------------------------------------
	// one event per match: the time holds a value for a whole second
	assign fire = module_on_q && alarm_enable_q && (time_q == alarm_time_q) &&
	              !match_seen_q; // R13

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_seen_q <= 1'b0;
		end else begin
			match_seen_q <= (time_q == alarm_time_q);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_event <= 1'b0;
		end else begin
			alarm_event <= fire;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_time_q <= rtc_pkg::TIME_RESET;
		end else if (wr_en && hit(paddr, rtc_pkg::ALTIM_OFFSET)) begin
			alarm_time_q <= pwdata[31:8];
		end
	end

	// sync flag: set while the alarm is armed and running, so software
	// knows the repeat count may change under it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_sync_flag_q <= 1'b0;
		end else begin
			alarm_sync_flag_q <= module_on_q && alarm_enable_q; // R5
		end
	end

	// ----------------------------------------------------------------
	// alarm control
	// ----------------------------------------------------------------
	// presetn is the power-on reset; no other reset source reaches here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			endless_repeat_q <= 1'b0; // R6
		end else if (wr_en && hit(paddr, rtc_pkg::ALARM_OFFSET)) begin
			endless_repeat_q <= pwdata[rtc_pkg::ALARM_ENDLESS_REPEAT_BIT];
		end
	end

	// hardware clear beats a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_enable_q <= 1'b0; // R6
		end else if (fire && alarm_repeat_count_q == 8'h00 && !endless_repeat_q) begin
			alarm_enable_q <= 1'b0; // R4
		end else if (wr_en && hit(paddr, rtc_pkg::ALARM_OFFSET)) begin
			alarm_enable_q <= pwdata[rtc_pkg::ALARM_EN_BIT];
		end
	end

	// the count is remaining repeats: n gives n+1 events in total
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_repeat_count_q <= rtc_pkg::RPT_RESET; // R6
		end else if (fire) begin
			if (alarm_repeat_count_q != 8'h00) begin
				alarm_repeat_count_q <= alarm_repeat_count_q - 8'h01; // R1 R2
			end else if (endless_repeat_q) begin
				alarm_repeat_count_q <= rtc_pkg::RPT_MAX; // R3
			end
		end else if (wr_en && hit(paddr, rtc_pkg::ALARM_OFFSET)) begin
			alarm_repeat_count_q <= pwdata[7:0];
		end
	end

endmodule : rtc_alarm_time

// ===== testbench/rtc_alarm_time_props.sv
`timescale 1ns/1ps
module rtc_alarm_time_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        alarm_event
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------------------------------------------------------------
	// bus timing: zero wait states, one answer per access
	// --------------------------------------------------------------
	logic mapped;
	assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C};
	property p_ack; psel && !penable |=> pready && psel && penable; endproperty
	a_ack: assert property (p_ack) else $error("no answer after setup");
	property p_setup; psel && !penable |-> !pready; endproperty
	a_setup: assert property (p_setup) else $error("answer during setup");
	property p_ackq; pready |-> psel && penable ##1 !pready; endproperty
	a_ackq: assert property (p_ackq) else $error("stray or long answer");
	property p_err; pslverr |-> pready && !mapped; endproperty
	a_err: assert property (p_err) else $error("error on mapped address");
	property p_unm; pready && !mapped |-> pslverr; endproperty
	a_unm: assert property (p_unm) else $error("unmapped access not refused");
	property p_urd; pready && !pwrite && !mapped |-> prdata == 32'h0000_0000; endproperty
	a_urd: assert property (p_urd) else $error("unmapped read not zero");
	property p_lowb;
		pready && !pwrite && paddr == rtc_pkg::TIME_OFFSET |-> prdata[7:0] == 8'h00;
	endproperty
	a_lowb: assert property (p_lowb) else $error("time low byte not zero");
	property p_evt; $rose(alarm_event) |=> !alarm_event [*3]; endproperty
	a_evt: assert property (p_evt) else $error("alarm pulse too long");
endmodule : rtc_alarm_time_props

// ===== testbench/rtc_alarm_time_tb.sv
`timescale 1ns/1ps
module rtc_alarm_time_tb;
	logic        pclk        = 1'b0;
	logic        presetn     = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [11:0] paddr       = 12'h000;
	logic [31:0] pwdata      = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        alarm_event;
	logic [31:0] rd;
	logic        er;
	logic [31:0] t;
	int          n;
	int          err_count   = 0;
	int          comparisons = 0;
	int          cyc         = 0;
	// carry corners: time written, time after one tick
	logic [47:0] steps [4]   = '{48'h2359_5900_0000, 48'h0059_5901_0000,
		48'h0959_5910_0000, 48'h0000_0900_0010};
	localparam logic [31:0] AMASK = 32'h0000_D0FF;

	initial forever #25 pclk = ~pclk;

	rtc_alarm_time #(.TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .alarm_event(alarm_event));

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no assumed latency: only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_evt();
		logic seen;
		seen = 1'b0;
		for (int k = 0; k < 200 && !seen; k++) begin
			@(posedge pclk);
			seen = (alarm_event === 1'b1);
		end
		chk("alarm_event", 32'h1, {31'h0, seen});
	endtask : wait_evt

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	initial begin
		void'($urandom(32'h957e_42f8));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0); chk("alarm_rst", 32'h0, rd);
		apb(1'b0, 12'h008, 32'h0); chk("time_rst", 32'h0, rd);
		apb(1'b1, 12'h008, 32'h1234_5600);
		apb(1'b0, 12'h008, 32'h0); chk("time_locked", 32'h0, rd);
		apb(1'b0, 12'h010, 32'h0); chk("unmapped_err", 32'h1, {31'h0, er});
		$display("test reset_and_lock done");
		apb(1'b1, 12'h000, 32'h0000_0008);
		for (int i = 0; i < 8; i++) begin
			t = {4'($urandom % 2), 4'($urandom % 10), 4'($urandom % 6),
				4'($urandom % 10), 4'($urandom % 6), 4'($urandom % 10), 8'($urandom)};
			apb(1'b1, 12'h008, t);
			apb(1'b0, 12'h008, 32'h0); chk("time_rw", {t[31:8], 8'h00}, rd);
		end
		$display("test time_rw done");
		apb(1'b1, 12'h000, 32'h0000_8008);
		foreach (steps[i]) begin
			apb(1'b1, 12'h008, {steps[i][47:24], 8'hFF});
			n = 0;
			do begin
				apb(1'b0, 12'h008, 32'h0);
				n++;
			end while (rd[31:8] === steps[i][47:24] && n < 20);
			chk("carry", {steps[i][23:0], 8'h00}, rd);
		end
		$display("test carry done");
		apb(1'b1, 12'h00C, 32'h1200_0000);
		apb(1'b1, 12'h004, 32'h0000_8001);
		apb(1'b1, 12'h008, 32'h1159_5900);
		wait_evt();
		apb(1'b0, 12'h004, 32'h0); chk("rpt_dec", 32'h0000_9000, rd & AMASK);
		apb(1'b1, 12'h008, 32'h1159_5900);
		wait_evt();
		apb(1'b0, 12'h004, 32'h0); chk("auto_off", 32'h0, rd & AMASK);
		apb(1'b1, 12'h004, 32'h0000_C000);
		apb(1'b1, 12'h008, 32'h1159_5900);
		wait_evt();
		apb(1'b0, 12'h004, 32'h0); chk("wrap", 32'h0000_D0FF, rd & AMASK);
		$display("test alarm done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0); chk("alarm_por", 32'h0, rd);
		apb(1'b0, 12'h008, 32'h0); chk("time_por", 32'h0, rd);
		$display("test power_on_reset done");
		end_of_test();
	end
endmodule : rtc_alarm_time_tb

bind rtc_alarm_time rtc_alarm_time_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_event(alarm_event));
